// [verilog/interrupt_enable_priority_regs.sv]
// Base priority, extended enable and extended priority registers with request gating
`timescale 1ns/1ps
// Contract
// - Base priority top bit reads one, ignores writes
// - Bits 6 and 4 set serial levels
// - Bits 5, 3, 1 set timer levels
// - Bits 2 and 0 set external levels
// - Ext enable bit 7 gates timer three
// - Ext enable bit 6 gates comparator one
// - Ext enable bit 5 gates comparator zero
// - Ext enable bit 4 gates counter array
// - Ext enable bit 3 gates conversion done
// - Ext enable bit 2 gates window compare
// - Ext enable bit 1 gates clock alarm
// - Ext enable bit 0 gates two-wire port
// - Ext priority bit 7 sets timer three level
// - Ext priority bits 6, 5 set comparator levels
// - Ext priority bit 4 sets counter array
// - Ext priority bits 3, 2 set converter levels
// - Ext priority bit 1 sets clock alarm
// - Ext priority bit 0 sets two-wire port
// - Global enable clear blocks every source
// - Disabling never touches pending flags
module interrupt_enable_priority_regs
    import irq_regs_pkg::*;
#(
    parameter int PCA_FLAGS = COUNTER_ARRAY_FLAGS
) (
    input  wire logic                     clk_in,
    input  wire logic                     reset_in,
    input  wire logic [7:0]               sfr_addr_in,
    input  wire logic                     sfr_write_in,
    input  wire logic                     sfr_read_in,
    input  wire logic [7:0]               sfr_wdata_in,
    output logic [7:0]                    sfr_rdata_out,
    output logic                          sfr_hit_out,
    input  wire logic                     global_interrupt_enable_in,
    input  wire logic [BASE_SOURCES-1:0]  base_enable_in,
    input  wire logic [BASE_SOURCES-1:0]  base_pending_in,
    input  wire logic                     timer_three_low_overflow_flag_in,
    input  wire logic                     timer_three_high_overflow_flag_in,
    input  wire logic                     comparator_one_rise_flag_in,
    input  wire logic                     comparator_one_fall_flag_in,
    input  wire logic                     comparator_zero_rise_flag_in,
    input  wire logic                     comparator_zero_fall_flag_in,
    input  wire logic [PCA_FLAGS-1:0]     counter_array_flags_in,
    input  wire logic                     conversion_done_flag_in,
    input  wire logic                     window_compare_flag_in,
    input  wire logic                     clock_alarm_flag_in,
    input  wire logic                     two_wire_port_flag_in,
    input  wire logic                     vector_taken_in,
    input  wire logic                     service_return_in,
    output logic [NUM_SOURCES-1:0]        source_request_out,
    output logic [NUM_SOURCES-1:0]        source_level_out,
    output logic                          irq_valid_out,
    output logic [SRC_INDEX_W-1:0]        irq_index_out,
    output logic                          irq_high_out,
    output logic [1:0]                    service_state_out
);
    initial begin
        if (PCA_FLAGS < 1) begin
            $error("PCA_FLAGS must be at least one");
        end
    end

    // Only seven base bits are stored; the top bit is not a flip-flop
    logic [BASE_SOURCES-1:0] base_level;
    logic [7:0]              ext_enable;
    logic [7:0]              ext_level;
    logic [NUM_SOURCES-1:0]  next_request;

    // Address decode
    wire sel_base_prio = (sfr_addr_in == PRIO_BASE_ADDR);
    wire sel_ext_en    = (sfr_addr_in == EXT_ENABLE_ADDR);
    wire sel_ext_prio  = (sfr_addr_in == EXT_PRIO_ADDR);
    wire wr_base_prio  = sfr_write_in && sel_base_prio;
    wire wr_ext_en     = sfr_write_in && sel_ext_en;
    wire wr_ext_prio   = sfr_write_in && sel_ext_prio;

    assign sfr_hit_out = sel_base_prio || sel_ext_en || sel_ext_prio;

    // Read data mux; the fixed top bit is forced here, not stored
    wire [7:0] base_prio_view = {1'b1, base_level};
    wire [7:0] next_rdata     = sel_base_prio ? base_prio_view :
                                sel_ext_en    ? ext_enable :
                                sel_ext_prio  ? ext_level :
                                UNMAPPED_READ;

    // Named register fields
    wire sync_serial_zero_level = base_level[SYNC_SERIAL_ZERO_BIT];
    wire async_serial_level     = base_level[ASYNC_SERIAL_BIT];
    wire timer_two_level        = base_level[TIMER_TWO_BIT];
    wire timer_one_level        = base_level[TIMER_ONE_BIT];
    wire timer_zero_level       = base_level[TIMER_ZERO_BIT];
    wire ext_int_one_level      = base_level[EXT_INT_ONE_BIT];
    wire ext_int_zero_level     = base_level[EXT_INT_ZERO_BIT];

    wire timer_three_enable     = ext_enable[TIMER_THREE_BIT];
    wire comparator_one_enable  = ext_enable[COMPARATOR_ONE_BIT];
    wire comparator_zero_enable = ext_enable[COMPARATOR_ZERO_BIT];
    wire counter_array_enable   = ext_enable[COUNTER_ARRAY_BIT];
    wire conversion_done_enable = ext_enable[CONVERSION_DONE_BIT];
    wire window_compare_enable  = ext_enable[WINDOW_COMPARE_BIT];
    wire clock_alarm_enable     = ext_enable[CLOCK_ALARM_BIT];
    wire two_wire_port_enable   = ext_enable[TWO_WIRE_PORT_BIT];

    wire timer_three_level      = ext_level[TIMER_THREE_BIT];
    wire comparator_one_level   = ext_level[COMPARATOR_ONE_BIT];
    wire comparator_zero_level  = ext_level[COMPARATOR_ZERO_BIT];
    wire counter_array_level    = ext_level[COUNTER_ARRAY_BIT];
    wire conversion_done_level  = ext_level[CONVERSION_DONE_BIT];
    wire window_compare_level   = ext_level[WINDOW_COMPARE_BIT];
    wire clock_alarm_level      = ext_level[CLOCK_ALARM_BIT];
    wire two_wire_port_level    = ext_level[TWO_WIRE_PORT_BIT];

    // Source-side pending, one bit per vector; flags are only read, never cleared here
    wire [EXT_SOURCES-1:0] ext_pending;
    assign ext_pending[TIMER_THREE_BIT]     = timer_three_low_overflow_flag_in ||
                                              timer_three_high_overflow_flag_in;
    assign ext_pending[COMPARATOR_ONE_BIT]  = comparator_one_rise_flag_in ||
                                              comparator_one_fall_flag_in;
    assign ext_pending[COMPARATOR_ZERO_BIT] = comparator_zero_rise_flag_in ||
                                              comparator_zero_fall_flag_in;
    assign ext_pending[COUNTER_ARRAY_BIT]   = |counter_array_flags_in;
    assign ext_pending[CONVERSION_DONE_BIT] = conversion_done_flag_in;
    assign ext_pending[WINDOW_COMPARE_BIT]  = window_compare_flag_in;
    assign ext_pending[CLOCK_ALARM_BIT]     = clock_alarm_flag_in;
    assign ext_pending[TWO_WIRE_PORT_BIT]   = two_wire_port_flag_in;

    wire [NUM_SOURCES-1:0] all_pending = {ext_pending, base_pending_in};
    wire [NUM_SOURCES-1:0] all_enable  = {ext_enable, base_enable_in};
    wire [NUM_SOURCES-1:0] all_level   = {ext_level, base_level};

    // Gating per source; a disabled source stays pending upstream
    genvar g;
    generate
        for (g = 0; g < NUM_SOURCES; g++) begin : gen_gate
            assign next_request[g] = all_pending[g] && all_enable[g] &&
                                     global_interrupt_enable_in;
        end
    endgenerate

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            base_level <= PRIO_BASE_RESET[BASE_SOURCES-1:0];
        end else if (wr_base_prio) begin
            base_level <= sfr_wdata_in[BASE_SOURCES-1:0];
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ext_enable <= EXT_ENABLE_RESET;
        end else if (wr_ext_en) begin
            ext_enable <= sfr_wdata_in;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ext_level <= EXT_PRIO_RESET;
        end else if (wr_ext_prio) begin
            ext_level <= sfr_wdata_in;
        end
    end

    // Read data holds until the next read strobe
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sfr_rdata_out <= UNMAPPED_READ;
        end else if (sfr_read_in) begin
            sfr_rdata_out <= next_rdata;
        end
    end

    // Registered so that the arbiter sees a settled request set
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            source_request_out <= '0;
            source_level_out   <= '0;
        end else begin
            source_request_out <= next_request;
            source_level_out   <= all_level;
        end
    end

    irq_service_arbiter #(
        .NUM_SRC           (NUM_SOURCES)
    ) u_arbiter (
        .clk_in            (clk_in),
        .reset_in          (reset_in),
        .request_in        (source_request_out),
        .level_in          (source_level_out),
        .vector_taken_in   (vector_taken_in),
        .service_return_in (service_return_in),
        .irq_valid_out     (irq_valid_out),
        .irq_index_out     (irq_index_out),
        .irq_high_out      (irq_high_out),
        .service_state_out (service_state_out)
    );

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    AST_TOP_BIT_READS_ONE: assert property (
        sfr_read_in && sel_base_prio |=> sfr_rdata_out[PRIO_FIXED_BIT] == 1'b1
    ) else $error("base priority top bit read as zero");

    AST_SERIAL_LEVELS: assert property (
        wr_base_prio |=> ##1 source_level_out[SYNC_SERIAL_ZERO_BIT] == $past(sfr_wdata_in[SYNC_SERIAL_ZERO_BIT], 2)
            && source_level_out[ASYNC_SERIAL_BIT] == $past(sfr_wdata_in[ASYNC_SERIAL_BIT], 2)
    ) else $error("serial port level not taken from write");

    AST_TIMER_LEVELS: assert property (
        wr_base_prio |=> timer_two_level == $past(sfr_wdata_in[TIMER_TWO_BIT])
            && timer_one_level == $past(sfr_wdata_in[TIMER_ONE_BIT])
            && timer_zero_level == $past(sfr_wdata_in[TIMER_ZERO_BIT])
    ) else $error("timer level not taken from write");

    AST_EXT_INT_LEVELS: assert property (
        wr_base_prio ##1 !wr_base_prio |=> ext_int_one_level == $past(sfr_wdata_in[EXT_INT_ONE_BIT], 2)
            && ext_int_zero_level == $past(sfr_wdata_in[EXT_INT_ZERO_BIT], 2)
    ) else $error("external interrupt level lost");

    AST_TIMER_THREE_PASSES: assert property (
        (timer_three_low_overflow_flag_in || timer_three_high_overflow_flag_in) && timer_three_enable
            && global_interrupt_enable_in |=> source_request_out[BASE_SOURCES + TIMER_THREE_BIT]
    ) else $error("timer three request not passed");

    AST_DISABLED_BLOCKS: assert property (
        !counter_array_enable |=> !source_request_out[BASE_SOURCES + COUNTER_ARRAY_BIT]
    ) else $error("counter array request passed while disabled");

    AST_EXT_LEVEL_WRITE: assert property (
        wr_ext_prio |=> ##1 source_level_out[NUM_SOURCES-1:BASE_SOURCES] == $past(sfr_wdata_in, 2)
    ) else $error("extended level not taken from write");

    AST_GLOBAL_OFF: assert property (
        !global_interrupt_enable_in |=> source_request_out == '0 ##1 !irq_valid_out || $past(irq_valid_out)
    ) else $error("request presented with global enable clear");

    AST_REQUEST_CAUSE: assert property (
        source_request_out != '0 |-> $past(global_interrupt_enable_in)
            && (($past(all_pending) & $past(all_enable)) == source_request_out)
    ) else $error("request without pending, enable and global enable");

    AST_LOW_NEVER_PREEMPTS: assert property (
        irq_valid_out && service_state_out != SVC_IDLE |-> irq_high_out
            && service_state_out == SVC_LOW
    ) else $error("low request offered over a running routine");

    AST_HIGH_FIRST: assert property (
        service_state_out == SVC_IDLE && !vector_taken_in && (source_request_out & source_level_out) != '0
            |=> irq_valid_out && irq_high_out
    ) else $error("high request not offered first");

    // Checked against the raw flags, so a wrong merge of a source's flags is caught too
    AST_CMP_ONE_GATE: assert property (
        source_request_out[BASE_SOURCES + COMPARATOR_ONE_BIT] == $past(comparator_one_enable
            && global_interrupt_enable_in && (comparator_one_rise_flag_in || comparator_one_fall_flag_in))
    ) else $error("comparator one request gated wrongly");

    AST_CMP_ZERO_GATE: assert property (
        source_request_out[BASE_SOURCES + COMPARATOR_ZERO_BIT] == $past(comparator_zero_enable
            && global_interrupt_enable_in && (comparator_zero_rise_flag_in || comparator_zero_fall_flag_in))
    ) else $error("comparator zero request gated wrongly");

    AST_CONV_DONE_GATE: assert property (
        source_request_out[BASE_SOURCES + CONVERSION_DONE_BIT] == $past(conversion_done_enable
            && global_interrupt_enable_in && conversion_done_flag_in)
    ) else $error("conversion done request gated wrongly");

    AST_WINDOW_GATE: assert property (
        source_request_out[BASE_SOURCES + WINDOW_COMPARE_BIT] == $past(window_compare_enable
            && global_interrupt_enable_in && window_compare_flag_in)
    ) else $error("window compare request gated wrongly");

    AST_ALARM_GATE: assert property (
        source_request_out[BASE_SOURCES + CLOCK_ALARM_BIT] == $past(clock_alarm_enable
            && global_interrupt_enable_in && clock_alarm_flag_in)
    ) else $error("clock alarm request gated wrongly");

    AST_TWO_WIRE_GATE: assert property (
        source_request_out[BASE_SOURCES + TWO_WIRE_PORT_BIT] == $past(two_wire_port_enable
            && global_interrupt_enable_in && two_wire_port_flag_in)
    ) else $error("two-wire port request gated wrongly");

    AST_TIMER_THREE_BLOCKED: assert property (
        !timer_three_enable |=> !source_request_out[BASE_SOURCES + TIMER_THREE_BIT]
    ) else $error("timer three request passed while disabled");

    AST_TAKEN_CLEARS_HIGH: assert property (
        vector_taken_in && irq_valid_out && irq_high_out |=> !irq_valid_out
    ) else $error("high offer kept after it was taken");

    COV_BASE_WRITE: cover property (wr_base_prio ##1 sfr_read_in && sel_base_prio);
    COV_TIMER_THREE: cover property (source_request_out[BASE_SOURCES + TIMER_THREE_BIT] && irq_valid_out);
    COV_PREEMPT: cover property (service_state_out == SVC_LOW ##[1:20] service_state_out == SVC_HIGH_LOW);
    COV_RETURN: cover property (service_state_out == SVC_HIGH_LOW ##1 service_state_out == SVC_LOW);
    COV_LOW_TAKEN: cover property (service_state_out == SVC_IDLE ##1 service_state_out == SVC_LOW);
endmodule

// [verilog/irq_regs_pkg.sv]
// Register map, field positions and source order of the interrupt enable and priority block
package irq_regs_pkg;
    // Register addresses on the special-function register bus
    localparam logic [7:0] PRIO_BASE_ADDR     = 8'hb8;
    localparam logic [7:0] EXT_ENABLE_ADDR    = 8'he6;
    localparam logic [7:0] EXT_PRIO_ADDR      = 8'hf6;
    localparam logic [7:0] UNMAPPED_READ      = 8'h00;
    // Reset values
    localparam logic [7:0] PRIO_BASE_RESET    = 8'h80;
    localparam logic [7:0] EXT_ENABLE_RESET   = 8'h00;
    localparam logic [7:0] EXT_PRIO_RESET     = 8'h00;
    // Base priority register fields
    localparam int PRIO_FIXED_BIT             = 7;
    localparam int SYNC_SERIAL_ZERO_BIT       = 6;
    localparam int TIMER_TWO_BIT              = 5;
    localparam int ASYNC_SERIAL_BIT           = 4;
    localparam int TIMER_ONE_BIT              = 3;
    localparam int EXT_INT_ONE_BIT            = 2;
    localparam int TIMER_ZERO_BIT             = 1;
    localparam int EXT_INT_ZERO_BIT           = 0;
    // Extended enable and priority register fields
    localparam int TIMER_THREE_BIT            = 7;
    localparam int COMPARATOR_ONE_BIT         = 6;
    localparam int COMPARATOR_ZERO_BIT        = 5;
    localparam int COUNTER_ARRAY_BIT          = 4;
    localparam int CONVERSION_DONE_BIT        = 3;
    localparam int WINDOW_COMPARE_BIT         = 2;
    localparam int CLOCK_ALARM_BIT            = 1;
    localparam int TWO_WIRE_PORT_BIT          = 0;
    // Source order, lowest index wins inside one level
    localparam int BASE_SOURCES               = 7;
    localparam int EXT_SOURCES                = 8;
    localparam int NUM_SOURCES                = 15;
    localparam int SRC_INDEX_W                = 4;
    localparam int COUNTER_ARRAY_FLAGS        = 7;
    // Service state of the core
    typedef enum logic [1:0] {
        SVC_IDLE      = 2'b00,
        SVC_LOW       = 2'b01,
        SVC_HIGH      = 2'b10,
        SVC_HIGH_LOW  = 2'b11
    } svc_state_e;
endpackage

// [verilog/irq_service_arbiter.sv]
// Two-level interrupt selection and service nesting tracker
`timescale 1ns/1ps
module irq_service_arbiter
    import irq_regs_pkg::*;
#(
    parameter int NUM_SRC = NUM_SOURCES
) (
    input  wire logic                   clk_in,
    input  wire logic                   reset_in,
    input  wire logic [NUM_SRC-1:0]     request_in,
    input  wire logic [NUM_SRC-1:0]     level_in,
    input  wire logic                   vector_taken_in,
    input  wire logic                   service_return_in,
    output logic                        irq_valid_out,
    output logic [SRC_INDEX_W-1:0]      irq_index_out,
    output logic                        irq_high_out,
    output logic [1:0]                  service_state_out
);
    initial begin
        if (NUM_SRC < 1 || NUM_SRC > (1 << SRC_INDEX_W)) begin
            $error("NUM_SRC out of range");
        end
    end

    svc_state_e             state;
    svc_state_e             next_state;
    logic                   hi_found;
    logic                   lo_found;
    logic [SRC_INDEX_W-1:0] hi_idx;
    logic [SRC_INDEX_W-1:0] lo_idx;

    wire taken       = vector_taken_in && irq_valid_out;
    wire offer_high  = hi_found && (next_state == SVC_IDLE || next_state == SVC_LOW);
    wire offer_low   = lo_found && (next_state == SVC_IDLE);
    wire next_valid  = offer_high || offer_low;
    wire [SRC_INDEX_W-1:0] next_index = offer_high ? hi_idx : lo_idx;

    // Descending scan leaves the lowest index found at each level
    always_comb begin
        hi_found = 1'b0;
        lo_found = 1'b0;
        hi_idx   = '0;
        lo_idx   = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (request_in[i] && level_in[i]) begin
                hi_found = 1'b1;
                hi_idx   = SRC_INDEX_W'(i);
            end
            if (request_in[i] && !level_in[i]) begin
                lo_found = 1'b1;
                lo_idx   = SRC_INDEX_W'(i);
            end
        end
    end

    // A high routine may nest inside a low one, never the other way
    always_comb begin
        next_state = state;
        case (state)
            SVC_IDLE: begin
                if (taken) begin
                    next_state = irq_high_out ? SVC_HIGH : SVC_LOW;
                end
            end
            SVC_LOW: begin
                if (taken) begin
                    next_state = SVC_HIGH_LOW;
                end else if (service_return_in) begin
                    next_state = SVC_IDLE;
                end
            end
            SVC_HIGH: begin
                if (service_return_in) begin
                    next_state = SVC_IDLE;
                end
            end
            SVC_HIGH_LOW: begin
                if (service_return_in) begin
                    next_state = SVC_LOW;
                end
            end
            default: next_state = SVC_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state         <= SVC_IDLE;
            irq_valid_out <= 1'b0;
            irq_index_out <= '0;
            irq_high_out  <= 1'b0;
        end else begin
            state         <= next_state;
            irq_valid_out <= next_valid;
            irq_index_out <= next_index;
            irq_high_out  <= offer_high;
        end
    end

    assign service_state_out = state;
endmodule

// [bench/core_vector_model.sv]
// Core-side model that accepts offered interrupt vectors
`timescale 1ns/1ps
module core_vector_model (
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic irq_valid_in,
    input  wire logic accept_in,
    output logic      vector_taken_out
);
    // One-cycle pulse, then a gap, so one offer is never taken twice
    always @(negedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            vector_taken_out <= 1'b0;
        end else begin
            vector_taken_out <= irq_valid_in & accept_in & ~vector_taken_out;
        end
    end
endmodule

// [bench/interrupt_enable_priority_regs_tb.sv]
// Testbench for the interrupt enable and priority registers
`timescale 1ns/1ps
module interrupt_enable_priority_regs_tb;
    import irq_regs_pkg::*;
    logic                   clk_in       = 1'b0;
    logic                   reset_in     = 1'b1;
    logic [7:0]             sfr_addr_in  = 8'h00;
    logic                   sfr_write_in = 1'b0;
    logic                   sfr_read_in  = 1'b0;
    logic [7:0]             sfr_wdata_in = 8'h00;
    logic                   glob         = 1'b0;
    logic [6:0]             base_en      = 7'h00;
    logic [6:0]             base_pend    = 7'h00;
    logic [10:0]            flag         = 11'h000;
    logic [6:0]             pca          = 7'h00;
    logic                   accept       = 1'b0;
    logic                   ret          = 1'b0;
    logic                   taken;
    logic [7:0]             sfr_rdata_out;
    logic                   sfr_hit_out;
    logic [NUM_SOURCES-1:0] req;
    logic [NUM_SOURCES-1:0] lvl;
    logic                   irq_valid_out;
    logic [3:0]             irq_index_out;
    logic                   irq_high_out;
    logic [1:0]             service_state_out;
    int                     err_count = 0;
    int                     compares  = 0;

    always #12.5 clk_in = ~clk_in;

    interrupt_enable_priority_regs dut (
        .clk_in(clk_in), .reset_in(reset_in), .sfr_addr_in(sfr_addr_in), .sfr_write_in(sfr_write_in),
        .sfr_read_in(sfr_read_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
        .sfr_hit_out(sfr_hit_out), .global_interrupt_enable_in(glob), .base_enable_in(base_en),
        .base_pending_in(base_pend), .timer_three_low_overflow_flag_in(flag[7]),
        .timer_three_high_overflow_flag_in(flag[10]), .comparator_one_rise_flag_in(flag[6]),
        .comparator_one_fall_flag_in(flag[9]), .comparator_zero_rise_flag_in(flag[5]),
        .comparator_zero_fall_flag_in(flag[8]), .counter_array_flags_in(pca),
        .conversion_done_flag_in(flag[3]), .window_compare_flag_in(flag[2]), .clock_alarm_flag_in(flag[1]),
        .two_wire_port_flag_in(flag[0]), .vector_taken_in(taken), .service_return_in(ret),
        .source_request_out(req), .source_level_out(lvl), .irq_valid_out(irq_valid_out),
        .irq_index_out(irq_index_out), .irq_high_out(irq_high_out), .service_state_out(service_state_out));

    core_vector_model core (.clk_in(clk_in), .reset_in(reset_in), .irq_valid_in(irq_valid_out),
        .accept_in(accept), .vector_taken_out(taken));

    task automatic report_and_stop();
        $display("counts: compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t register read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t output %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_in = a;
        sfr_wdata_in = d;
        sfr_write_in = 1'b1;
        tick(1);
        sfr_write_in = 1'b0;
        tick(1);
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [7:0] e, input logic hit);
        sfr_addr_in = a;
        sfr_read_in = 1'b1;
        tick(1);
        chk_out({15'h0, sfr_hit_out}, {15'h0, hit});
        sfr_read_in = 1'b0;
        tick(1);
        chk_reg(sfr_rdata_out, e);
    endtask

    task automatic offer(input logic v, input logic h, input logic [3:0] i);
        chk_out({10'h0, irq_valid_out, irq_high_out, irq_index_out}, {10'h0, v, h, i});
    endtask

    // Bounded wait on the nesting state; a hang ends the run
    task automatic wait_state(input logic [1:0] s);
        int n;
        n = 0;
        while (service_state_out !== s && n < 10) begin
            tick(1);
            n++;
        end
        chk_out({14'h0, service_state_out}, {14'h0, s});
        if (service_state_out !== s) report_and_stop();
    endtask

    task automatic ret_pulse();
        ret = 1'b1;
        tick(1);
        ret = 1'b0;
        tick(1);
    endtask

    // Raise or drop one flag of extended source j; alt picks a two-flag source's second flag, or pca bit 6 for j 4
    task automatic set_ext(input int j, input int alt, input logic v);
        if (j == 4) pca[alt * 6] = v;
        else if (alt == 1 && j > 4) flag[j + 3] = v;
        else flag[j] = v;
    endtask

    initial begin
        tick(5);
        reset_in = 1'b0;
        reg_read(PRIO_BASE_ADDR, 8'h80, 1'b1);
        reg_read(EXT_ENABLE_ADDR, 8'h00, 1'b1);
        reg_read(EXT_PRIO_ADDR, 8'h00, 1'b1);
        reg_read(8'hb9, 8'h00, 1'b0);
        $display("test reset_values done");
        reg_write(PRIO_BASE_ADDR, 8'h55);
        reg_read(PRIO_BASE_ADDR, 8'hd5, 1'b1);
        reg_write(PRIO_BASE_ADDR, 8'haa);
        reg_write(EXT_PRIO_ADDR, 8'h5a);
        reg_write(8'hb9, 8'hff);
        reg_read(PRIO_BASE_ADDR, 8'haa, 1'b1);
        reg_read(EXT_PRIO_ADDR, 8'h5a, 1'b1);
        chk_out({1'b0, lvl}, {1'b0, 8'h5a, 7'h2a});
        reg_write(PRIO_BASE_ADDR, 8'h55);
        reg_write(EXT_PRIO_ADDR, 8'ha5);
        tick(1);
        chk_out({1'b0, lvl}, {1'b0, 8'ha5, 7'h55});
        $display("test register_access done");
        glob = 1'b1;
        base_en = 7'h7f;
        for (int i = 0; i < 7; i++) begin
            base_pend = 7'h01 << i;
            tick(3);
            chk_out({1'b0, req}, 16'h0001 << i);
            offer(1'b1, 1'(8'h55 >> i), 4'(i));
            glob = 1'b0;
            tick(3);
            chk_out({1'b0, req}, 16'h0000);
            glob = 1'b1;
        end
        base_pend = 7'h00;
        for (int j = 0; j < 8; j++) begin
            for (int alt = 0; alt < 2; alt++) begin
                reg_write(EXT_ENABLE_ADDR, 8'h01 << j);
                set_ext(j, alt, 1'b1);
                tick(3);
                chk_out({1'b0, req}, 16'h0080 << j);
                offer(1'b1, 1'(8'ha5 >> j), 4'(7 + j));
                reg_write(EXT_ENABLE_ADDR, ~(8'h01 << j));
                tick(3);
                chk_out({1'b0, req}, 16'h0000);
                set_ext(j, alt, 1'b0);
            end
        end
        $display("test source_gating done");
        reg_write(PRIO_BASE_ADDR, 8'h00);
        reg_write(EXT_PRIO_ADDR, 8'h80);
        reg_write(EXT_ENABLE_ADDR, 8'h80);
        base_pend = 7'h01;
        flag[7] = 1'b1;
        tick(3);
        offer(1'b1, 1'b1, 4'd14);
        accept = 1'b1;
        wait_state(2'b10);
        accept = 1'b0;
        tick(3);
        chk_out({14'h0, irq_valid_out, irq_high_out}, 16'h0000);
        flag[7] = 1'b0;
        ret_pulse();
        wait_state(2'b00);
        tick(3);
        offer(1'b1, 1'b0, 4'd0);
        accept = 1'b1;
        wait_state(2'b01);
        accept = 1'b0;
        base_pend = 7'h03;
        tick(3);
        chk_out({14'h0, irq_valid_out, irq_high_out}, 16'h0000);
        flag[10] = 1'b1;
        tick(3);
        offer(1'b1, 1'b1, 4'd14);
        accept = 1'b1;
        wait_state(2'b11);
        accept = 1'b0;
        flag[10] = 1'b0;
        ret_pulse();
        wait_state(2'b01);
        ret_pulse();
        wait_state(2'b00);
        $display("test priority_nesting done");
        report_and_stop();
    end
endmodule
